// ===== hw/pcmd_mem.sv
`timescale 1ns/1ps
module pcmd_mem #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned ADDR_BITS = 13
) (
    // Clock
    input wire logic aclk,
    // Port
    input wire logic we,
    input wire logic [ADDR_BITS-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [2**ADDR_BITS];

    // Single port, registered read; no reset so it maps onto block RAM
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : pcmd_mem

// ===== hw/pcmd_pkg.sv
// Operation
// - Item codes 1-8: position to control method
// - Item codes 9-16: pattern to repeat step
// - Step 1-150 selects step, 0 current step
// - Data change on moving axis gives 472
// - Teach run on moving axis: 461/463
// - Teach entry n at consecutive staging words
// - Teach write stores exactly requested count, max 16
// - Teach entries go to consecutive steps
// - Teach run covers at most sixteen steps
// - Method 1 saves to flash, 0 RAM only
// - Selector 0 goal position, 1 speed
// - Save copies selected axes data to flash
// - Save while any axis moves gives 172
// - Save mask bit0 X, bit1 Y
// - Homing on moving axis gives 201
// - Direct start on moving axis gives 221
// - Per-axis operating flag readable
// - Per-axis error flag set on error
// - Axis selector 0 or 1
// - Direct start goal is signed 32-bit
package pcmd_pkg;
    localparam int unsigned AXES = 2;
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 32;
    localparam int unsigned STEP_W = 8;
    localparam int unsigned ITEM_W = 4;
    localparam int unsigned CNT_W = 5;
    localparam int unsigned MEM_AW = 1 + STEP_W + ITEM_W;
    localparam int unsigned WORD_LSB = 2;
    // Register byte offsets
    localparam logic [AW-1:0] ADDR_MASK = 8'hfc;
    localparam logic [AW-1:0] REG_CMD = 8'h00;
    localparam logic [AW-1:0] REG_ARG0 = 8'h04;
    localparam logic [AW-1:0] REG_ARG1 = 8'h08;
    localparam logic [AW-1:0] REG_STAT = 8'h0c;
    localparam logic [AW-1:0] REG_ERRC = 8'h10;
    localparam logic [AW-1:0] STAGE_BASE = 8'h40;
    localparam logic [AW-1:0] STAGE_END = 8'h7c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Reject codes
    localparam logic [15:0] ERR_CHG_BUSY = 16'h01d8;
    localparam logic [15:0] ERR_PTEACH_BUSY = 16'h01cd;
    localparam logic [15:0] ERR_STEACH_BUSY = 16'h01cf;
    localparam logic [15:0] ERR_SAVE_BUSY = 16'h00ac;
    localparam logic [15:0] ERR_HOME_BUSY = 16'h00c9;
    localparam logic [15:0] ERR_DST_BUSY = 16'h00dd;
    localparam logic [15:0] ERR_ARG = 16'h0fff;
    // Current-step selector, memory rows beyond the step range, field codes
    localparam logic [STEP_W-1:0] STEP_CUR = 8'h00;
    localparam logic [STEP_W-1:0] STAGE_STEP = 8'hfe;
    localparam logic [STEP_W-1:0] TABLE_STEP = 8'hff;
    localparam logic SEL_SPEED = 1'b1;
    localparam logic METHOD_NV = 1'b1;

    typedef logic [STEP_W-1:0] pcmd_step_t;
    typedef enum logic [4:0] {
        IT_GOAL = 5'h01, IT_ARC_AUX = 5'h02, IT_SPEED = 5'h03, IT_DWELL = 5'h04,
        IT_MCODE = 5'h05, IT_ARC_TURNS = 5'h06, IT_OP_METHOD = 5'h07, IT_CTRL = 5'h08,
        IT_PATTERN = 5'h09, IT_COORD = 5'h0a, IT_ARC_SIZE = 5'h0b, IT_ACC_NO = 5'h0c,
        IT_DEC_NO = 5'h0d, IT_ARC_METHOD = 5'h0e, IT_ARC_DIR = 5'h0f, IT_REPEAT = 5'h10
    } pcmd_item_t;
    typedef enum logic [2:0] {
        OP_NONE = 3'b000, OP_CHG = 3'b001, OP_TWR = 3'b010, OP_TRUN = 3'b011,
        OP_SAVE = 3'b100, OP_HOME = 3'b101, OP_DST = 3'b110
    } pcmd_op_t;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RD = 2'b01, ST_WR = 2'b10} pcmd_st_t;
    typedef struct packed {
        logic [26:0] rsv;
        logic axis;
        logic rsv1;
        pcmd_op_t op;
    } pcmd_cmd_t;
    typedef struct packed {
        logic [15:0] rsv;
        pcmd_step_t step;
        logic [2:0] rsv1;
        logic [4:0] item;
    } pcmd_chg_t;
    typedef struct packed {
        logic [13:0] rsv;
        logic sel;
        logic method;
        logic [2:0] rsv1;
        logic [CNT_W-1:0] cnt;
        pcmd_step_t first;
    } pcmd_arg_t;
    typedef struct packed {
        logic [26:0] rsv;
        logic busy;
        logic [1:0] err;
        logic [1:0] oper;
    } pcmd_stat_t;
    typedef struct packed {
        logic [AXES-1:0] home_start;
        logic [AXES-1:0] dst_start;
        logic signed [31:0] dst_goal;
        logic save_req;
        logic [AXES-1:0] save_mask;
    } pcmd_motion_t;
    typedef struct packed {
        pcmd_st_t st;
        logic teach_data_write_cmd;
        logic axis;
        pcmd_arg_t run;
        logic [CNT_W-1:0] idx;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [DW-1:0] rdata;
        logic [DW-1:0] arg0;
        logic [DW-1:0] arg1;
        logic [AXES-1:0] err_flag;
        logic [AXES-1:0][15:0] err_code;
        pcmd_motion_t mo;
    } pcmd_state_t;
endpackage : pcmd_pkg

// ===== hw/pcmd_top.sv
`timescale 1ns/1ps
module pcmd_top
    import pcmd_pkg::*;
#(
    parameter int unsigned N_STEPS = 150,
    parameter int unsigned TEACH_MAX = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [DW-1:0] wdata,
    input wire logic [DW/8-1:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [AW-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [DW-1:0] rdata,
    output logic [1:0] rresp,
    // Motion engine side
    input wire logic [AXES-1:0] motion_active,
    input wire logic [AXES-1:0] axis_fault,
    input wire pcmd_step_t [AXES-1:0] cur_step,
    output pcmd_motion_t motion
);
    localparam pcmd_step_t MAX_STEP = pcmd_step_t'(N_STEPS);
    localparam logic [CNT_W-1:0] TMAX = CNT_W'(TEACH_MAX);

    // Reserved rows above the steps hold staging and teach tables
    if (N_STEPS < 1 || N_STEPS > 253 || TEACH_MAX < 1 || TEACH_MAX > 16) begin : g_chk
        $error("pcmd_top: N_STEPS or TEACH_MAX out of range");
    end

    pcmd_state_t q, d;
    logic mem_we;
    logic [MEM_AW-1:0] mem_addr;
    logic [DW-1:0] mem_wdata;
    logic [DW-1:0] mem_rdata;
    logic [AW-1:0] wa, ra;
    logic wr_go, ar_go, cmd_acc, in_stage;
    pcmd_cmd_t cmd_w;
    pcmd_chg_t chg;
    pcmd_arg_t arg;
    logic [8:0] run_last;

    function automatic logic [MEM_AW-1:0] maddr(input logic ax, input pcmd_step_t st,
                                                input logic [ITEM_W-1:0] it);
        return {ax, st, it};
    endfunction : maddr

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                            input logic [DW-1:0] nw,
                                            input logic [DW/8-1:0] strb);
        logic [DW-1:0] r;
        r = old;
        for (int i = 0; i < DW / 8; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    pcmd_mem #(.WIDTH(DW), .ADDR_BITS(MEM_AW)) u_mem (
        .aclk(aclk),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // Request decode; writes wait while the copy engine owns the memory
    assign wa = awaddr & ADDR_MASK;
    assign ra = araddr & ADDR_MASK;
    assign wr_go = awvalid && wvalid && !q.bvalid && q.st == ST_IDLE;
    assign ar_go = arvalid && !q.rvalid;
    assign cmd_acc = wr_go && wa == REG_CMD;
    assign in_stage = wa >= STAGE_BASE && wa <= STAGE_END;
    assign cmd_w = pcmd_cmd_t'(wdata);
    assign chg = pcmd_chg_t'(q.arg0);
    assign arg = pcmd_arg_t'(q.arg0);
    assign run_last = 9'(arg.first) + 9'(arg.cnt) - 9'h001;

    // Next state: bus slave, command issue, copy engine
    always_comb begin
        logic rej;
        logic [15:0] rej_code;
        logic ax;
        pcmd_step_t tstep;
        rej = 1'b0;
        rej_code = '0;
        ax = cmd_w.axis;
        tstep = pcmd_step_t'(q.run.first + pcmd_step_t'(q.idx));
        d = q;
        d.mo.home_start = '0;
        d.mo.dst_start = '0;
        d.mo.save_req = 1'b0;
        mem_we = 1'b0;
        mem_addr = '0;
        mem_wdata = '0;
        awready = wr_go;
        wready = wr_go;
        arready = ar_go;
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (wr_go) begin
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            if (in_stage) begin
                // Entry n lands at staging word n-1
                mem_we = 1'b1;
                mem_addr = maddr(1'b0, STAGE_STEP, wa[WORD_LSB +: ITEM_W]);
                mem_wdata = wdata;
            end else begin
                case (wa)
                    REG_ARG0: d.arg0 = merge(q.arg0, wdata, wstrb);
                    REG_ARG1: d.arg1 = merge(q.arg1, wdata, wstrb);
                    REG_STAT: d.err_flag = q.err_flag & ~wdata[3:2];
                    REG_CMD: begin
                        unique case (cmd_w.op)
                            OP_CHG: begin
                                if (motion_active[ax]) begin
                                    rej = 1'b1;
                                    rej_code = ERR_CHG_BUSY;
                                end else if (chg.item < IT_GOAL || chg.item > IT_REPEAT ||
                                             chg.step > MAX_STEP) begin
                                    rej = 1'b1;
                                    rej_code = ERR_ARG;
                                end else begin
                                    // Item code picks the word within the step row
                                    mem_we = 1'b1;
                                    mem_addr = maddr(ax, (chg.step == STEP_CUR) ?
                                                     cur_step[ax] : chg.step,
                                                     ITEM_W'(chg.item - IT_GOAL));
                                    mem_wdata = q.arg1;
                                end
                            end
                            OP_TWR: begin
                                if (arg.cnt > TMAX) begin
                                    rej = 1'b1;
                                    rej_code = ERR_ARG;
                                end else if (arg.cnt != '0) begin
                                    d.st = ST_RD;
                                    d.teach_data_write_cmd = 1'b1;
                                    d.axis = ax;
                                    d.run = arg;
                                    d.idx = '0;
                                end
                            end
                            OP_TRUN: begin
                                if (motion_active[ax]) begin
                                    rej = 1'b1;
                                    rej_code = (arg.sel == SEL_SPEED) ?
                                               ERR_STEACH_BUSY : ERR_PTEACH_BUSY;
                                end else if (arg.cnt > TMAX || arg.cnt == '0 ||
                                             arg.first == STEP_CUR ||
                                             run_last > 9'(MAX_STEP)) begin
                                    rej = 1'b1;
                                    rej_code = ERR_ARG;
                                end else begin
                                    d.st = ST_RD;
                                    d.teach_data_write_cmd = 1'b0;
                                    d.axis = ax;
                                    d.run = arg;
                                    d.idx = '0;
                                end
                            end
                            OP_SAVE: begin
                                if (|motion_active) begin
                                    rej = 1'b1;
                                    rej_code = ERR_SAVE_BUSY;
                                end else begin
                                    d.mo.save_req = 1'b1;
                                    d.mo.save_mask = q.arg0[AXES-1:0];
                                end
                            end
                            OP_HOME: begin
                                if (motion_active[ax]) begin
                                    rej = 1'b1;
                                    rej_code = ERR_HOME_BUSY;
                                end else begin
                                    d.mo.home_start[ax] = 1'b1;
                                end
                            end
                            OP_DST: begin
                                if (motion_active[ax]) begin
                                    rej = 1'b1;
                                    rej_code = ERR_DST_BUSY;
                                end else begin
                                    d.mo.dst_start[ax] = 1'b1;
                                    d.mo.dst_goal = $signed(q.arg1);
                                end
                            end
                            default: ;
                        endcase
                    end
                    default: d.bresp = RESP_DECERR;
                endcase
            end
        end
        // Copy engine: read a word, then write it one cycle later
        unique case (q.st)
            ST_IDLE: ;
            ST_RD: begin
                // Teach run reads the table that a teach write filled
                mem_addr = q.teach_data_write_cmd ? maddr(1'b0, STAGE_STEP, q.idx[ITEM_W-1:0]) :
                           maddr(q.axis, TABLE_STEP, q.idx[ITEM_W-1:0]);
                d.st = ST_WR;
            end
            ST_WR: begin
                mem_we = 1'b1;
                mem_wdata = mem_rdata;
                if (q.teach_data_write_cmd) begin
                    mem_addr = maddr(q.axis, TABLE_STEP, q.idx[ITEM_W-1:0]);
                end else begin
                    mem_addr = maddr(q.axis, tstep, (q.run.sel == SEL_SPEED) ?
                                     ITEM_W'(IT_SPEED - IT_GOAL) :
                                     ITEM_W'(IT_GOAL - IT_GOAL));
                end
                d.idx = q.idx + CNT_W'(1);
                d.st = ST_RD;
                if (q.idx == q.run.cnt - CNT_W'(1)) begin
                    d.st = ST_IDLE;
                    if (!q.teach_data_write_cmd && q.run.method == METHOD_NV) begin
                        // Nonvolatile teaching flushes the axis to flash
                        d.mo.save_req = 1'b1;
                        d.mo.save_mask = '0;
                        d.mo.save_mask[q.axis] = 1'b1;
                    end
                end
            end
            default: d.st = ST_IDLE;
        endcase
        // Reads
        if (ar_go) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            case (ra)
                REG_ARG0: d.rdata = q.arg0;
                REG_ARG1: d.rdata = q.arg1;
                REG_STAT: d.rdata = pcmd_stat_t'{rsv: '0, busy: q.st != ST_IDLE,
                                                 err: q.err_flag,
                                                 oper: motion_active};
                REG_ERRC: d.rdata = q.err_code;
                default: d.rresp = RESP_DECERR;
            endcase
        end
        // Set wins over the software clear above
        if (rej) begin
            d.err_flag[ax] = 1'b1;
            d.err_code[ax] = rej_code;
        end
        d.err_flag = d.err_flag | axis_fault;
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign motion = q.mo;

    // Helper: words written by the current copy
    logic [CNT_W-1:0] wr_cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || q.st == ST_IDLE) begin
            wr_cnt_q <= '0;
        end else if (q.st == ST_WR) begin
            wr_cnt_q <= wr_cnt_q + CNT_W'(1);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_chg_busy;
        (cmd_acc && cmd_w.op == OP_CHG && motion_active[cmd_w.axis])
            |=> (q.err_flag[$past(cmd_w.axis)] &&
                 q.err_code[$past(cmd_w.axis)] == ERR_CHG_BUSY);
    endproperty
    a_chg_busy: assert property (p_chg_busy) else $error("busy change not rejected");

    property p_trun_busy;
        (cmd_acc && cmd_w.op == OP_TRUN && motion_active[cmd_w.axis])
            |=> (q.st == ST_IDLE && q.err_code[$past(cmd_w.axis)] ==
                 (($past(arg.sel) == SEL_SPEED) ? ERR_STEACH_BUSY : ERR_PTEACH_BUSY));
    endproperty
    a_trun_busy: assert property (p_trun_busy) else $error("teach run code wrong");

    property p_save_busy;
        (cmd_acc && cmd_w.op == OP_SAVE)
            |=> (motion.save_req != $past(|motion_active)) &&
                (!$past(|motion_active) || q.err_code[$past(cmd_w.axis)] == ERR_SAVE_BUSY);
    endproperty
    a_save_busy: assert property (p_save_busy) else $error("save gating wrong");

    property p_home;
        (cmd_acc && cmd_w.op == OP_HOME)
            |=> (motion.home_start[$past(cmd_w.axis)] == !$past(motion_active[cmd_w.axis]))
                ##1 (motion.home_start == '0);
    endproperty
    a_home: assert property (p_home) else $error("homing start wrong");

    property p_dst;
        (cmd_acc && cmd_w.op == OP_DST && !motion_active[cmd_w.axis])
            |=> (motion.dst_start[$past(cmd_w.axis)] && motion.dst_goal == $past(q.arg1));
    endproperty
    a_dst: assert property (p_dst) else $error("direct start goal wrong");

    property p_wr_count;
        (q.st == ST_WR && q.idx == q.run.cnt - CNT_W'(1))
            |=> (q.st == ST_IDLE && $past(wr_cnt_q) + CNT_W'(1) == $past(q.run.cnt));
    endproperty
    a_wr_count: assert property (p_wr_count) else $error("copy count wrong");

    property p_nv_save;
        (q.st == ST_WR && !q.teach_data_write_cmd && q.idx == q.run.cnt - CNT_W'(1))
            |=> (motion.save_req == ($past(q.run.method) == METHOD_NV));
    endproperty
    a_nv_save: assert property (p_nv_save) else $error("teach save wrong");

    property p_fault;
        (axis_fault != '0) |=> ((q.err_flag & $past(axis_fault)) == $past(axis_fault));
    endproperty
    a_fault: assert property (p_fault) else $error("error flag lost");

    property p_step0;
        (cmd_acc && cmd_w.op == OP_CHG && mem_we && chg.step == STEP_CUR)
            |-> (mem_addr[ITEM_W +: STEP_W] == cur_step[cmd_w.axis]);
    endproperty
    a_step0: assert property (p_step0) else $error("current step not used");

    property p_run_addr;
        (q.st == ST_WR && !q.teach_data_write_cmd)
            |-> (mem_addr[ITEM_W +: STEP_W] == pcmd_step_t'(q.run.first + q.idx) &&
                 mem_addr[ITEM_W-1:0] == ((q.run.sel == SEL_SPEED) ?
                 ITEM_W'(IT_SPEED - IT_GOAL) : ITEM_W'(IT_GOAL - IT_GOAL)));
    endproperty
    a_run_addr: assert property (p_run_addr) else $error("teach target wrong");
endmodule : pcmd_top

// ===== verif/pcmd_motion_model.sv
`timescale 1ns/1ps
module pcmd_motion_model
    import pcmd_pkg::*;
#(
    parameter int HOLD = 300
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Requests from the handler
    input wire pcmd_motion_t motion,
    input wire logic [AXES-1:0] fault_req,
    // Engine state
    output logic [AXES-1:0] motion_active,
    output logic [AXES-1:0] axis_fault
);
    int cnt [AXES];
    // A start keeps the axis moving for a fixed span, long enough for a burst of rejects
    always @(posedge aclk) begin
        for (int a = 0; a < AXES; a++) begin
            if (!aresetn) cnt[a] <= 0;
            else if (motion.home_start[a] || motion.dst_start[a]) cnt[a] <= HOLD;
            else if (cnt[a] != 0) cnt[a] <= cnt[a] - 1;
        end
    end
    // Operating flag and fault event as seen by the handler
    always_comb begin
        for (int a = 0; a < AXES; a++) motion_active[a] = (cnt[a] != 0);
        axis_fault = fault_req;
    end
endmodule : pcmd_motion_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module testbench;
    import pcmd_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [AW-1:0] awaddr = '0, araddr = '0;
    logic [DW-1:0] wdata = '0, rdata, rd_v;
    logic [DW/8-1:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs, last_mask, fault = '0, motion_active, axis_fault;
    pcmd_step_t [AXES-1:0] cur_step = '{8'h05, 8'h03};
    pcmd_motion_t motion;
    int err_count = 0, num_checks = 0, saves = 0;
    always #12.5 aclk = ~aclk;
    // Count flash requests, keep the last mask
    always @(posedge aclk) if (motion.save_req) begin
        saves <= saves + 1;
        last_mask <= motion.save_mask;
    end
    pcmd_top #(.N_STEPS(150), .TEACH_MAX(16)) pcmd_top_inst (.aclk, .aresetn, .awvalid, .awready,
        .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .motion_active, .axis_fault, .cur_step, .motion);
    pcmd_motion_model #(.HOLD(300)) pcmd_motion_model_inst (.aclk, .aresetn, .motion,
        .fault_req(fault), .motion_active, .axis_fault);
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge aclk);
        {awvalid, wvalid, bready} <= 3'b111;
        awaddr <= a;
        wdata <= d;
        @(posedge aclk iff (awready && wready));
        {awvalid, wvalid} <= 2'b00;
        @(posedge aclk iff bvalid);
        rs = bresp;
        bready <= 0;
    endtask : wr
    task automatic rd(input logic [AW-1:0] a);
        @(posedge aclk);
        {arvalid, rready} <= 2'b11;
        araddr <= a;
        @(posedge aclk iff arready);
        arvalid <= 0;
        @(posedge aclk iff rvalid);
        rd_v = rdata;
        rs = rresp;
        rready <= 0;
    endtask : rd
    task automatic cmd(input logic [2:0] op, input logic ax, input logic [DW-1:0] a0);
        wr(REG_ARG0, a0);
        wr(REG_CMD, {27'h0, ax, 1'b0, op});
    endtask : cmd
    // Error flags are not a gate in the handler, so the bench bypasses them on purpose
    task automatic code_is(input logic [15:0] e);
        rd(REG_ERRC);
        `CHK("err_code", e, rd_v[15:0])
        rd(REG_STAT);
        `CHK("err_flag", 1'b1, rd_v[2])
        wr(REG_STAT, 32'hc);
    endtask : code_is
    task automatic wait_idle();
        for (int k = 0; k < 200; k++) begin
            rd(REG_STAT);
            if (rd_v[1:0] === 2'b00 && rd_v[4] === 1'b0) break;
        end
        `CHK("idle", 3'b000, {rd_v[4], rd_v[1:0]})
    endtask : wait_idle
    task automatic t_start();
        wr(REG_ARG1, 32'hfffffffb);
        cmd(OP_DST, 1'b1, '0);
        `CHK("dst_goal", 32'hfffffffb, motion.dst_goal)
        cmd(OP_HOME, 1'b0, '0);
        rd(REG_STAT);
        `CHK("oper", 2'b11, rd_v[1:0])
    endtask : t_start
    task automatic t_reject();
        logic [2:0] ops [6] = '{OP_CHG, OP_TRUN, OP_TRUN, OP_SAVE, OP_HOME, OP_DST};
        logic [DW-1:0] a0 [6] = '{32'h0101, 32'h0201, 32'h20201, 32'h3, 32'h0, 32'h0};
        logic [15:0] ex [6] = '{16'd472, 16'd461, 16'd463, 16'd172, 16'd201, 16'd221};
        wr(REG_ARG1, 32'h7);
        // Only byte lane 1 may land
        wstrb <= 4'h2;
        wr(REG_ARG1, 32'hffffffff);
        wstrb <= 4'hf;
        for (int i = 0; i < 6; i++) begin
            cmd(ops[i], 1'b0, a0[i]);
            code_is(ex[i]);
        end
        `CHK("dst_goal_kept", 32'hfffffffb, motion.dst_goal)
        rd(REG_ARG1);
        `CHK("arg1_kept", 32'h0000ff07, rd_v)
    endtask : t_reject
    task automatic t_items_save();
        int s0;
        for (int i = 1; i <= 16; i++) cmd(OP_CHG, 1'b0, {16'h0, (i == 16) ? 8'd150 : 8'd0, 3'h0, 5'(i)});
        rd(REG_STAT);
        `CHK("chg_err", 2'b00, rd_v[3:2])
        s0 = saves;
        cmd(OP_SAVE, 1'b1, 32'h3);
        repeat (3) @(posedge aclk);
        `CHK("save_count", s0 + 1, saves)
        `CHK("save_mask", 2'b11, last_mask)
        fault <= 2'b10;
        @(posedge aclk);
        fault <= 2'b00;
        rd(REG_STAT);
        `CHK("fault_flag", 2'b10, rd_v[3:2])
    endtask : t_items_save
    task automatic t_teach();
        int s0;
        wr(REG_STAT, 32'hc);
        for (int n = 1; n <= 16; n++) wr(STAGE_BASE + 8'(4 * (n - 1)), 32'(n));
        cmd(OP_TWR, 1'b0, 32'h1001);
        rd(REG_STAT);
        `CHK("twr_err", 2'b00, rd_v[3:2])
        cmd(OP_TWR, 1'b0, 32'h1101);
        code_is(16'h0fff);
        cmd(OP_TRUN, 1'b0, 32'h1101);
        code_is(16'h0fff);
        s0 = saves;
        cmd(OP_TRUN, 1'b0, 32'h11087);
        wait_idle();
        `CHK("nv_save", s0 + 1, saves)
        `CHK("nv_mask", 2'b01, last_mask)
        cmd(OP_TRUN, 1'b0, 32'h21001);
        wait_idle();
        `CHK("ram_only", s0 + 1, saves)
        `CHK("run_err", 2'b00, rd_v[3:2])
        rd(8'h20);
        `CHK("unmapped", 2'b11, rs)
        wr(REG_ERRC, 32'h0);
        `CHK("wr_decerr", 2'b11, rs)
        rd(REG_ERRC);
        `CHK("code_kept", 32'h00000fff, rd_v)
    endtask : t_teach
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // Main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        t_start();
        t_reject();
        wait_idle();
        t_items_save();
        t_teach();
        give_verdict();
    end
    // Watchdog well beyond the expected run
    initial begin
        #(25 * 30000);
        err_count++;
        give_verdict();
    end
endmodule : testbench
